// ===== shared/sie_pkg.sv
// Purpose: constants, types and helpers shared by the subtract executor
// Assumes: 16-bit instruction words, 8-bit data, 12-bit file address
// Notes: status byte holds carry in bit 0 up to sign in bit 4
// Notes on behaviour
// - literal op computes immediate minus working_accumulator, result to accumulator
// - upper byte 0000 1000 marks literal op; low byte is the immediate
// - literal op updates sign, overflow, carry, half borrow and zero flags
// - literal op is one word and finishes in one instruction cycle
// - quarters: decode, read immediate, process, write accumulator
// - zero result sets zero flag and carry (no borrow)
// - subtrahend above minuend wraps, clears carry; 2-3 gives 0xFF, sign set
// - register op computes file register minus accumulator, five flags, opcode 010111
// - destination bit 0 writes accumulator, 1 writes back file register
// - bank bit 0 uses access bank, 1 combines address with bank_pointer
package sie_pkg;

    // ==========================================================
    // register map of the plain bus port
    localparam logic [3:0] SIE_OFS_INSTR = 4'h0;
    localparam logic [3:0] SIE_OFS_WACC = 4'h1;
    localparam logic [3:0] SIE_OFS_BANK = 4'h2;
    localparam logic [3:0] SIE_OFS_STATUS = 4'h3;
    localparam logic [3:0] SIE_OFS_FADDR = 4'h4;
    localparam logic [3:0] SIE_OFS_FDATA = 4'h5;

    // ==========================================================
    // fields and reset values
    localparam int SIE_ST_ILLEGAL_BIT = 6;
    localparam int SIE_ST_BUSY_BIT = 7;
    localparam int SIE_DEST_BIT = 9;
    localparam int SIE_BANKSEL_BIT = 8;
    localparam int SIE_FILE_AW = 12;
    localparam logic [7:0] SIE_WACC_RST = 8'h00;
    localparam logic [3:0] SIE_BANK_RST = 4'h0;
    localparam logic [15:0] SIE_INSTR_RST = 16'h0000;
    localparam logic [11:0] SIE_FADDR_RST = 12'h000;

    // ==========================================================
    // opcodes and access bank split
    localparam logic [7:0] SIE_OPC_LIT = 8'h08;
    localparam logic [5:0] SIE_OPC_REG = 6'h17;
    localparam logic [7:0] SIE_ACC_SPLIT = 8'h80;
    localparam logic [3:0] SIE_ACC_BANK_LO = 4'h0;
    localparam logic [3:0] SIE_ACC_BANK_HI = 4'hF;

    // ==========================================================
    // timing: mclk cycles in one instruction cycle
    localparam int SIE_QUARTERS = 4;

    typedef enum logic [1:0] {
        SIE_Q1 = 2'b00,
        SIE_Q2 = 2'b01,
        SIE_Q3 = 2'b10,
        SIE_Q4 = 2'b11
    } sie_quarter_t;

    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } sie_flags_t;

    typedef struct packed {
        logic [7:0] res;
        sie_flags_t fl;
    } sie_alu_t;

    typedef struct packed {
        logic is_lit;
        logic is_reg;
        logic to_file;
        logic [11:0] addr;
        logic [7:0] lit;
    } sie_ctrl_t;

    // 8-bit subtract m - s with status flags
    function automatic sie_alu_t sie_sub(input logic [7:0] m, input logic [7:0] s);
        logic [8:0] full;
        logic [4:0] low;
        sie_alu_t r;
        full = {1'b0, m} - {1'b0, s};
        low = {1'b0, m[3:0]} - {1'b0, s[3:0]};
        r.res = full[7:0];
        r.fl.c = ~full[8];
        r.fl.dc = ~low[4];
        r.fl.z = (full[7:0] == 8'h00);
        r.fl.n = full[7];
        r.fl.ov = (m[7] != s[7]) && (full[7] != m[7]);
        return r;
    endfunction : sie_sub

    // decode an instruction word against the current bank pointer
    function automatic sie_ctrl_t sie_decode(input logic [15:0] w, input logic [3:0] bank);
        sie_ctrl_t c;
        c.is_lit = (w[15:8] == SIE_OPC_LIT);
        c.is_reg = (w[15:10] == SIE_OPC_REG);
        c.to_file = w[SIE_DEST_BIT];
        c.lit = w[7:0];
        if (w[SIE_BANKSEL_BIT]) begin
            c.addr = {bank, w[7:0]};
        end else if (w[7:0] < SIE_ACC_SPLIT) begin
            c.addr = {SIE_ACC_BANK_LO, w[7:0]};
        end else begin
            c.addr = {SIE_ACC_BANK_HI, w[7:0]};
        end
        return c;
    endfunction : sie_decode

endpackage : sie_pkg

// ===== hdl/sie_qseq.sv
// Purpose: free-running quarter phase sequencer of the instruction cycle
// Assumes: four mclk cycles per instruction cycle
// Notes: starts in the first quarter after reset
`timescale 1ns/100ps
module sie_qseq (
    input wire logic mclk,
    input wire logic srst,
    output sie_pkg::sie_quarter_t quarter
);

    // ==========================================================
    // quarter counter, wraps from fourth back to first
    sie_pkg::sie_quarter_t next_quarter;

    assign next_quarter = sie_pkg::sie_quarter_t'(quarter + 2'b01);

    always_ff @(posedge mclk) begin
        if (srst) begin
            quarter <= sie_pkg::SIE_Q1;
        end else begin
            quarter <= next_quarter;
        end
    end

endmodule : sie_qseq

// ===== hdl/sie_fmem.sv
// Purpose: file register memory, single port, registered read data
// Assumes: one access per mclk cycle
// Notes: read-first; a write returns the old word that cycle
`timescale 1ns/100ps
module sie_fmem #(
    parameter int AW = 12,
    parameter int DW = 8
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [AW-1:0] addr,
    input wire logic we,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata
);

    // ==========================================================
    // storage, no reset: contents are software's business
    logic [DW-1:0] mem [0:(2**AW)-1];

    always_ff @(posedge mclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    // read register, cleared by reset so it is never unknown during reset
    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata <= '0;
        end else begin
            rdata <= mem[addr];
        end
    end

endmodule : sie_fmem

// ===== hdl/sie_exec.sv
// Purpose: executes the two subtract instructions over four quarters
// Assumes: bus master obeys one-cycle strobes, never both at once
// Notes: instructions are issued by writing the instruction register
// Notes: file data read while busy follow the executor's address, not the window
`timescale 1ns/100ps
module sie_exec (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [3:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [15:0] bus_rdata,
    output logic exec_busy
);

    // ==========================================================
    // declarations

    sie_pkg::sie_quarter_t quarter;

    // issue path
    logic pending;
    logic next_pending;
    logic [15:0] instr_hold;
    logic [15:0] ir;
    logic next_busy;

    // per-instruction pipeline state
    sie_pkg::sie_ctrl_t ctrl;
    sie_pkg::sie_ctrl_t dec_now;
    logic [7:0] operand;
    logic [7:0] acc_snap;
    sie_pkg::sie_alu_t alu;
    sie_pkg::sie_alu_t alu_now;

    // architectural state
    logic [7:0] working_accumulator;
    logic [3:0] bank_pointer;
    sie_pkg::sie_flags_t flags;
    logic illegal;
    logic [11:0] faddr;

    // memory port
    logic [11:0] mem_addr;
    logic mem_we;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;

    // ==========================================================
    // bus decode

    logic sel_instr;
    logic sel_wacc;
    logic sel_bank;
    logic sel_status;
    logic sel_faddr;
    logic sel_fdata;
    logic wr_instr;
    logic wr_wacc;
    logic wr_bank;
    logic wr_status;
    logic wr_faddr;
    logic wr_fdata;
    logic sw_idle;

    // address match per register
    assign sel_instr = (bus_addr == sie_pkg::SIE_OFS_INSTR);
    assign sel_wacc = (bus_addr == sie_pkg::SIE_OFS_WACC);
    assign sel_bank = (bus_addr == sie_pkg::SIE_OFS_BANK);
    assign sel_status = (bus_addr == sie_pkg::SIE_OFS_STATUS);
    assign sel_faddr = (bus_addr == sie_pkg::SIE_OFS_FADDR);
    assign sel_fdata = (bus_addr == sie_pkg::SIE_OFS_FDATA);

    // executor state is only open to software between cycles
    assign sw_idle = !exec_busy;

    // state owned by the executor refuses writes while busy,
    // so software never races the quarter pipeline
    assign wr_instr = bus_wr && sel_instr;
    assign wr_wacc = bus_wr && sel_wacc && sw_idle;
    assign wr_bank = bus_wr && sel_bank && sw_idle;
    assign wr_status = bus_wr && sel_status && sw_idle;
    assign wr_faddr = bus_wr && sel_faddr;
    assign wr_fdata = bus_wr && sel_fdata && sw_idle;

    // ==========================================================
    // quarter phases

    logic at_q1;
    logic at_q2;
    logic at_q3;
    logic at_q4;
    logic load_now;

    sie_qseq u_qseq (
        .mclk(mclk),
        .srst(srst),
        .quarter(quarter)
    );

    // one-hot views of the current quarter
    assign at_q1 = (quarter == sie_pkg::SIE_Q1);
    assign at_q2 = (quarter == sie_pkg::SIE_Q2);
    assign at_q3 = (quarter == sie_pkg::SIE_Q3);
    assign at_q4 = (quarter == sie_pkg::SIE_Q4);

    // quarter strobes of the executor's own cycle; outside busy
    // the sequencer keeps running but nothing in the pipeline moves
    logic ex_q1;
    logic ex_q2;
    logic ex_q3;
    logic ex_q4;

    assign ex_q1 = exec_busy && at_q1;
    assign ex_q2 = exec_busy && at_q2;
    assign ex_q3 = exec_busy && at_q3;
    assign ex_q4 = exec_busy && at_q4;

    // a pending word enters at the end of a cycle, so it
    // always gets a full Q1..Q4 of its own
    assign load_now = at_q4 && pending;

    // ==========================================================
    // issue: pending flag, held word, instruction register

    // a new write in the loading cycle stays pending: set wins
    assign next_pending = wr_instr ? 1'b1 : (load_now ? 1'b0 : pending);

    // busy covers exactly one instruction cycle per word
    assign next_busy = load_now ? 1'b1 : (at_q4 ? 1'b0 : exec_busy);

    always_ff @(posedge mclk) begin
        if (srst) begin
            pending <= 1'b0;
            exec_busy <= 1'b0;
        end else begin
            pending <= next_pending;
            exec_busy <= next_busy;
        end
    end

    // held word and instruction register
    always_ff @(posedge mclk) begin
        if (srst) begin
            instr_hold <= sie_pkg::SIE_INSTR_RST;
            ir <= sie_pkg::SIE_INSTR_RST;
        end else begin
            if (wr_instr) begin
                instr_hold <= bus_wdata;
            end
            if (load_now) begin
                ir <= instr_hold;
            end
        end
    end

    // ==========================================================
    // Q1: decode

    // bank pointer is frozen while busy, so decode sees a
    // stable value for the whole cycle
    assign dec_now = sie_pkg::sie_decode(ir, bank_pointer);

    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl <= '0;
        end else if (ex_q1) begin
            ctrl <= dec_now;
        end
    end

    // ==========================================================
    // memory port sharing

    // executor address during Q1 comes straight from decode, so
    // the registered read data are ready in Q2
    assign mem_addr = ex_q1 ? dec_now.addr :
                      exec_busy ? ctrl.addr : faddr;

    // Q4 write-back to the file, else software's data port; the
    // two never meet because data port writes wait for idle
    logic ex_file_wb;

    assign ex_file_wb = ex_q4 && ctrl.is_reg && ctrl.to_file;
    assign mem_we = ex_file_wb || wr_fdata;
    assign mem_wdata = exec_busy ? alu.res : bus_wdata[7:0];

    sie_fmem #(
        .AW(sie_pkg::SIE_FILE_AW),
        .DW(8)
    ) u_fmem (
        .mclk(mclk),
        .srst(srst),
        .addr(mem_addr),
        .we(mem_we),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    // ==========================================================
    // Q2: read operand

    // literal from the word itself, or the addressed register
    logic [7:0] next_operand;

    assign next_operand = ctrl.is_lit ? ctrl.lit : mem_rdata;

    // accumulator is sampled with the operand, so a late software
    // write can never leak into a running subtraction
    always_ff @(posedge mclk) begin
        if (srst) begin
            operand <= 8'h00;
            acc_snap <= 8'h00;
        end else if (ex_q2) begin
            operand <= next_operand;
            acc_snap <= working_accumulator;
        end
    end

    // ==========================================================
    // Q3: process data

    // both ops subtract the accumulator from the other operand
    assign alu_now = sie_pkg::sie_sub(operand, acc_snap);

    always_ff @(posedge mclk) begin
        if (srst) begin
            alu <= '0;
        end else if (ex_q3) begin
            alu <= alu_now;
        end
    end

    // ==========================================================
    // Q4: write destination and flags

    logic wb_acc;
    logic wb_flags;
    logic bad_op;
    logic clr_illegal;

    // literal op always lands in the accumulator; register op
    // only when the destination bit is clear
    assign wb_acc = ex_q4 && (ctrl.is_lit || (ctrl.is_reg && !ctrl.to_file));
    assign wb_flags = ex_q4 && (ctrl.is_lit || ctrl.is_reg);

    // any other word only marks itself; software clears the mark
    // by writing a one into the illegal bit while idle
    assign bad_op = ex_q4 && !ctrl.is_lit && !ctrl.is_reg;
    assign clr_illegal = wr_status && bus_wdata[sie_pkg::SIE_ST_ILLEGAL_BIT];

    // accumulator: executor write or idle software write
    always_ff @(posedge mclk) begin
        if (srst) begin
            working_accumulator <= sie_pkg::SIE_WACC_RST;
        end else if (wb_acc) begin
            working_accumulator <= alu.res;
        end else if (wr_wacc) begin
            working_accumulator <= bus_wdata[7:0];
        end
    end

    // status flags, written by execution or by idle software
    always_ff @(posedge mclk) begin
        if (srst) begin
            flags <= '0;
        end else if (wb_flags) begin
            flags <= alu.fl;
        end else if (wr_status) begin
            flags <= bus_wdata[4:0];
        end
    end

    // unsupported words do nothing but raise a sticky flag;
    // the raise wins over a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            illegal <= 1'b0;
        end else if (bad_op) begin
            illegal <= 1'b1;
        end else if (clr_illegal) begin
            illegal <= 1'b0;
        end
    end

    // ==========================================================
    // software-only registers

    // bank pointer, refused while busy so a running decode
    // never sees it move under its feet
    always_ff @(posedge mclk) begin
        if (srst) begin
            bank_pointer <= sie_pkg::SIE_BANK_RST;
        end else if (wr_bank) begin
            bank_pointer <= bus_wdata[3:0];
        end
    end

    // file window address, always open: it steers only the
    // software data port, never the executor
    always_ff @(posedge mclk) begin
        if (srst) begin
            faddr <= sie_pkg::SIE_FADDR_RST;
        end else if (wr_faddr) begin
            faddr <= bus_wdata[11:0];
        end
    end

    // ==========================================================
    // read data

    logic [15:0] status_word;
    logic [15:0] img_wacc;
    logic [15:0] img_bank;
    logic [15:0] img_faddr;
    logic [15:0] img_fdata;
    logic [15:0] rd_mux;

    // busy and illegal sit above the five arithmetic flags
    assign status_word = {8'h00, exec_busy, illegal, 1'b0, flags};

    // narrow registers read back zero-extended to the bus width
    assign img_wacc = {8'h00, working_accumulator};
    assign img_bank = {12'h000, bank_pointer};
    assign img_faddr = {4'h0, faddr};
    assign img_fdata = {8'h00, mem_rdata};

    // unmapped offsets read as zero; file data are only valid
    // when idle and one cycle after the window address moved
    assign rd_mux = sel_instr ? instr_hold :
                    sel_wacc ? img_wacc :
                    sel_bank ? img_bank :
                    sel_status ? status_word :
                    sel_faddr ? img_faddr :
                    sel_fdata ? img_fdata : 16'h0000;

    // data stand only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (srst) begin
            bus_rdata <= 16'h0000;
        end else begin
            bus_rdata <= bus_rd ? rd_mux : 16'h0000;
        end
    end

endmodule : sie_exec

// ===== tb/sie_exec_props.sv
// Purpose: port-level checks of the subtract executor
// Assumes: single mclk domain, srst synchronous and active high
// Notes: bound to sie_exec at the foot of this file
`timescale 1ns/100ps
module sie_exec_chk (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [3:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [15:0] bus_rdata,
    input wire logic exec_busy
);
    // ==========================================================
    // clocking and named steps
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    sequence seq_instr_wr;
        bus_wr && bus_addr == 4'h0;
    endsequence

    sequence seq_acc_wr;
        bus_wr && bus_addr == 4'h1 && !exec_busy;
    endsequence

    // ==========================================================
    // bus read port
    AST_RDATA_IDLE: assert property (!$past(bus_rd) |-> bus_rdata == 16'h0000)
        else $error("read data not zero outside read slot");
    AST_UNMAPPED: assert property (bus_rd && bus_addr > 4'h5 |=> bus_rdata == 16'h0000)
        else $error("unmapped index read not zero");
    AST_BYTE_UPPER: assert property (bus_rd && bus_addr inside {4'h1, 4'h2, 4'h3, 4'h5}
        |=> bus_rdata[15:8] == 8'h00)
        else $error("upper byte of byte register not zero");
    AST_BANK_UPPER: assert property (bus_rd && bus_addr == 4'h2 |=> bus_rdata[7:4] == 4'h0)
        else $error("bank pointer upper bits not zero");
    AST_STATUS_GAP: assert property (bus_rd && bus_addr == 4'h3 |=> bus_rdata[5] == 1'b0)
        else $error("unused status bit not zero");
    AST_INSTR_BACK: assert property (seq_instr_wr ##2 (bus_rd && bus_addr == 4'h0)
        |=> bus_rdata == $past(bus_wdata, 3))
        else $error("instruction word readback wrong");
    AST_ACC_BACK: assert property (seq_acc_wr ##2 (bus_rd && bus_addr == 4'h1 && !exec_busy)
        |=> bus_rdata == {8'h00, $past(bus_wdata[7:0], 3)})
        else $error("accumulator readback wrong");

    // ==========================================================
    // instruction cycle framing
    AST_BUSY_FOUR: assert property ($rose(exec_busy) |-> exec_busy [*4])
        else $error("busy shorter than four quarters");
    AST_BUSY_GAP: assert property ($fell(exec_busy) |-> !exec_busy [*4])
        else $error("busy rose before next cycle boundary");
    // queued word must start within nine mclk cycles of its write
    AST_ISSUE_LAT: assert property (seq_instr_wr ##0 !exec_busy |-> ##[1:9] exec_busy)
        else $error("issued word never started");
endmodule : sie_exec_chk

bind sie_exec sie_exec_chk u_chk (
    .mclk(mclk),
    .srst(srst),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .bus_wr(bus_wr),
    .bus_rd(bus_rd),
    .bus_rdata(bus_rdata),
    .exec_busy(exec_busy)
);

// ===== tb/tb_top.sv
// Purpose: self-checking bench for the subtract executor
// Assumes: bus tasks leave one idle cycle between strobes
// Notes: expected flags worked out locally, never from the design
`timescale 1ns/100ps
module tb_top;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] bus_addr = 4'h0;
    logic [15:0] bus_wdata = 16'h0000;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [15:0] bus_rdata;
    logic exec_busy;
    int num_errors = 0;
    int n_compared = 0;
    logic [15:0] got;
    logic [7:0] lit_k [5] = '{8'h02, 8'h02, 8'h02, 8'h80, 8'h10};
    logic [7:0] lit_w [5] = '{8'h01, 8'h02, 8'h03, 8'h01, 8'h01};

    // ==========================================================
    // clock and device
    always #10 mclk = ~mclk;

    sie_exec uut (.mclk(mclk), .srst(srst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .exec_busy(exec_busy));

    // ==========================================================
    // reporting
    task automatic conclude();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // ==========================================================
    // bus access, one idle cycle after each strobe
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge mclk);
        bus_wr <= 1'b0;
    endtask : wr

    // data stands only in the cycle after the strobe, so sample mid-cycle
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge mclk);
        bus_rd <= 1'b0;
        @(negedge mclk);
        got = bus_rdata;
    endtask : rd

    task automatic rdchk(input string what, input logic [3:0] a, input logic [15:0] exp);
        rd(a);
        chk(what, exp, got);
    endtask : rdchk

    // status image: n, ov, z, dc, c of m - s
    function automatic logic [15:0] exp_st(input logic [7:0] m, input logic [7:0] s);
        logic [7:0] r;
        r = m - s;
        return {11'h000, r[7], (m[7] != s[7]) && (r[7] != m[7]), m == s,
            m[3:0] >= s[3:0], m >= s};
    endfunction : exp_st

    // ==========================================================
    // issue and completion, bounded waits
    task automatic start(input logic [15:0] w);
        int i;
        wr(4'h0, w);
        rdchk("instr", 4'h0, w);
        for (i = 0; i < 12 && exec_busy !== 1'b1; i++) @(negedge mclk);
        if (exec_busy !== 1'b1) begin
            num_errors++;
            conclude();
        end
    endtask : start

    task automatic finish_op();
        int i;
        for (i = 0; i < 16 && exec_busy !== 1'b0; i++) @(negedge mclk);
        if (exec_busy !== 1'b0) begin
            num_errors++;
            conclude();
        end
    endtask : finish_op

    // register op with bank pointer fixed at 3
    task automatic run_reg(input logic [15:0] w, input logic [11:0] fa, input logic [7:0] fv,
        input logic [7:0] acc, input logic [7:0] fexp, input logic [7:0] aexp);
        wr(4'h2, 16'h0003);
        wr(4'h1, {8'h00, acc});
        wr(4'h4, {4'h0, fa});
        wr(4'h5, {8'h00, fv});
        start(w);
        finish_op();
        rdchk("reg acc", 4'h1, {8'h00, aexp});
        wr(4'h4, {4'h0, fa});
        rdchk("reg file", 4'h5, {8'h00, fexp});
        rdchk("reg status", 4'h3, exp_st(fv, acc));
    endtask : run_reg

    // ==========================================================
    // main sequence
    initial begin
        int i;
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        rdchk("acc reset", 4'h1, 16'h0000);
        rdchk("bank reset", 4'h2, 16'h0000);
        rdchk("status reset", 4'h3, 16'h0000);
        rdchk("faddr reset", 4'h4, 16'h0000);
        rdchk("unmapped", 4'hF, 16'h0000);
        wr(4'hE, 16'hFFFF);
        wr(4'h1, 16'hAB5A);
        rdchk("acc low byte", 4'h1, 16'h005A);
        // literal cases: plain, zero, wrap, signed overflow, half borrow
        for (i = 0; i < 5; i++) begin
            wr(4'h1, {8'h00, lit_w[i]});
            start({8'h08, lit_k[i]});
            finish_op();
            rdchk("lit acc", 4'h1, {8'h00, lit_k[i] - lit_w[i]});
            rdchk("lit status", 4'h3, exp_st(lit_k[i], lit_w[i]));
        end
        // decoy in banked slot catches a wrong access bank mapping
        wr(4'h4, 16'h0320);
        wr(4'h5, 16'h0077);
        run_reg(16'h5F45, 12'h345, 8'h03, 8'h02, 8'h01, 8'h02);
        run_reg(16'h5C20, 12'h020, 8'h02, 8'h02, 8'h02, 8'h00);
        run_reg(16'h5E90, 12'hF90, 8'h02, 8'h03, 8'hFF, 8'h03);
        rdchk("bank", 4'h2, 16'h0003);
        // word outside both encodings leaves the accumulator alone
        wr(4'h1, 16'h0011);
        wr(4'h0, 16'h5401);
        got = 16'h0000;
        for (i = 0; i < 10 && got[6] !== 1'b1; i++) rd(4'h3);
        chk("illegal", 16'h0040, got & 16'h0040);
        rdchk("acc kept", 4'h1, 16'h0011);
        wr(4'h3, 16'h0040);
        rdchk("status cleared", 4'h3, 16'h0000);
        // software write lands mid-cycle and must lose
        wr(4'h1, 16'h0005);
        start(16'h0807);
        wr(4'h1, 16'h0055);
        finish_op();
        rdchk("acc busy write", 4'h1, 16'h0002);
        // two words back to back, busy never drops
        wr(4'h1, 16'h0001);
        start(16'h0805);
        start(16'h0805);
        finish_op();
        rdchk("acc b2b", 4'h1, 16'h0001);
        rdchk("status b2b", 4'h3, exp_st(8'h05, 8'h04));
        // second reset mid-run
        @(posedge mclk);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rdchk("acc rereset", 4'h1, 16'h0000);
        rdchk("status rereset", 4'h3, 16'h0000);
        rdchk("bank rereset", 4'h2, 16'h0000);
        conclude();
    end
endmodule : tb_top
